// >>> rtl/lac_match.sv
`timescale 1ns/1ns
`default_nettype none
module lac_match #(
  parameter int TW = 8,
  parameter bit EDGE = 1'b1
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // probed trigger port
  input wire logic [TW-1:0] trig_i,
  // settings and results
  lac_mu_if.unit mu
);
  import lac_pkg::*;
  logic [TW-1:0] prev_reg;
  logic [CNT_W-1:0] cnt_reg;
  logic sat_reg;
  logic [TW-1:0] bit_ok;
  logic reach;

  always_comb
  begin
    for (int i = 0; i < TW; i++)
    begin
      // a unit without edge logic treats edge codes as don't care
      unique case (lac_bit_t'(mu.mode[3*i +: 3]))
        BM_X: bit_ok[i] = 1'b1;
        BM_ZERO: bit_ok[i] = ~trig_i[i];
        BM_ONE: bit_ok[i] = trig_i[i];
        BM_RISE: bit_ok[i] = ~EDGE | (trig_i[i] & ~prev_reg[i]);
        BM_FALL: bit_ok[i] = ~EDGE | (~trig_i[i] & prev_reg[i]);
        BM_EDGE: bit_ok[i] = ~EDGE | (trig_i[i] ^ prev_reg[i]);
        BM_STILL: bit_ok[i] = ~EDGE | ~(trig_i[i] ^ prev_reg[i]);
        default: bit_ok[i] = 1'b1;
      endcase
    end
  end

  assign mu.hit = (&bit_ok) ^ mu.neg;
  assign reach = mu.hit && ({1'b0, cnt_reg} + 17'h00001 >= {1'b0, mu.n});

  always_ff @(posedge mclk_i)
  begin
    // follows the pin through reset too, so release shows no false edge
    prev_reg <= trig_i;
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i || mu.clr)
    begin
      cnt_reg <= '0;
      sat_reg <= 1'b0;
    end
    else
    begin
      unique case (mu.cmode)
        CM_OFF: cnt_reg <= '0;
        CM_EXACT: cnt_reg <= reach ? '0 : cnt_reg + CNT_W'(mu.hit);
        CM_ATLEAST:
        begin
          if (mu.hit && !reach)
            cnt_reg <= cnt_reg + 16'h0001;
          sat_reg <= sat_reg | reach;
        end
        CM_CONSEC:
        begin
          if (!mu.hit)
            cnt_reg <= '0;
          else if (!reach)
            cnt_reg <= cnt_reg + 16'h0001;
        end
      endcase
    end
  end

  always_comb
  begin
    unique case (mu.cmode)
      CM_OFF: mu.sat = mu.hit;
      CM_ATLEAST: mu.sat = sat_reg | reach;
      default: mu.sat = reach;
    endcase
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  atleast_hold_a: assert property (
    (mu.cmode == CM_ATLEAST && mu.sat && !mu.clr) ##1 (mu.cmode == CM_ATLEAST && !mu.clr)
      |-> mu.sat)
    else $error("at-least match dropped before trigger");
  consec_drop_a: assert property (
    (mu.cmode == CM_CONSEC && !mu.hit) |-> !mu.sat)
    else $error("consecutive match held without a hit");
endmodule
`default_nettype wire

// >>> rtl/lac_mu_if.sv
`timescale 1ns/1ns
`default_nettype none
interface lac_mu_if #(parameter int TW = 8);
  logic [3*TW-1:0] mode;
  logic neg;
  lac_pkg::lac_cnt_t cmode;
  logic [lac_pkg::CNT_W-1:0] n;
  logic clr;
  logic hit;
  logic sat;
  modport unit (input mode, input neg, input cmode, input n, input clr, output hit, output sat);
  modport ctl (output mode, output neg, output cmode, output n, output clr, input hit, input sat);
endinterface
`default_nettype wire

// >>> rtl/lac_pkg.sv
`default_nettype none
package lac_pkg;
  // register byte offsets
  localparam logic [7:0] A_CTRL = 8'h00;
  localparam logic [7:0] A_STS = 8'h04;
  localparam logic [7:0] A_MASK = 8'h08;
  localparam logic [7:0] A_CAP = 8'h0C;
  localparam logic [7:0] A_WINS = 8'h10;
  localparam logic [7:0] A_POS = 8'h14;
  localparam logic [7:0] A_NSMP = 8'h18;
  localparam logic [7:0] A_TRG = 8'h1C;
  localparam logic [7:0] A_STO = 8'h20;
  localparam logic [7:0] A_RADR = 8'h24;
  localparam logic [7:0] A_RDAT = 8'h28;
  localparam logic [7:0] A_FILL = 8'h2C;
  localparam logic [7:0] A_MU = 8'h40;
  localparam int MU_STRIDE = 16;
  localparam logic [1:0] MU_MODE = 2'h0;
  localparam logic [1:0] MU_FUNC = 2'h1;
  localparam logic [1:0] MU_CNT = 2'h2;
  // control and status bits
  localparam int C_ARM = 0;
  localparam int C_STOP = 1;
  localparam int C_FORCE = 2;
  localparam int I_TRIG = 0;
  localparam int I_DONE = 1;
  localparam int I_ERR = 2;
  localparam int I_W = 3;
  // capture configuration fields
  localparam int K_TYPE = 0;
  localparam int K_LOG = 4;
  localparam int K_LOG_W = 4;
  // condition fields, shared by trigger and storage
  localparam int Q_EN = 0;
  localparam int Q_NEG = 8;
  localparam int Q_OR = 16;
  localparam int Q_INV = 17;
  localparam int Q_ALL = 18;
  localparam int Q_W = 19;
  localparam logic [18:0] TRG_RST = 19'h000FF;
  localparam logic [18:0] STO_RST = 19'h40000;
  // match unit function fields
  localparam int F_NEG = 0;
  localparam int F_CM = 4;
  localparam int F_W = 6;
  localparam int CNT_W = 16;
  localparam logic [15:0] CNT_RST = 16'h0001;
  localparam int MAX_UNITS = 8;
  localparam int MIN_CNT_DEPTH = 8;
  typedef enum logic [2:0] {BM_X, BM_ZERO, BM_ONE, BM_RISE, BM_FALL, BM_EDGE, BM_STILL} lac_bit_t;
  typedef enum logic [1:0] {CM_OFF, CM_EXACT, CM_ATLEAST, CM_CONSEC} lac_cnt_t;
endpackage
`default_nettype wire

// >>> rtl/lac_top.sv
// Functional notes
// - match values, conditions and capture settings live in writable registers.
// - every capture window holds exactly one trigger sample.
// - windowed type uses power-of-two window depth, trigger anywhere inside.
// - windowed type accepts window counts from 1 to buffer depth.
// - windowed type trigger position 0 to depth minus one places the trigger.
// - fixed-samples type puts trigger at sample 0, fills as many windows as fit.
// - fixed-samples count accepts 1 up to buffer depth.
// - counter modes at-least or consecutive need window length of at least 8.
// - storage qualifier judges match events every clock, per sample.
// - storage stores all, or AND/OR of enabled units, per-unit and whole invert.
// - each trigger bit is X, 0, 1; edge units add rise, fall, either, none.
// - a unit only performs its built-in comparisons, chosen by its function.
// - exactly-n and at-least-n count n events; at-least holds until trigger.
// - consecutive-n needs n back-to-back hits, holds until trigger or miss.
// - trigger defaults to AND of all units; else AND/OR with inversions.
// - armed block waits for trigger or disarm, captures, stops when full.
//
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module lac_top #(
  parameter int TW = 8,
  parameter int DW = 8,
  parameter int AW = 6,
  parameter int NU = 2,
  parameter bit EDGE = 1'b1
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // probed logic
  input wire logic [TW-1:0] trig_i,
  input wire logic [DW-1:0] data_i,
  // interrupt
  output logic irq_o
);
  import lac_pkg::*;
  localparam int BUF = 1 << AW;
  typedef enum logic [1:0] {ST_IDLE, ST_PRE, ST_POST, ST_DONE} lac_state_t;

  if (NU < 1 || NU > MAX_UNITS || TW < 1 || TW > 10 || DW < 1 || DW > 31 || AW < 3 || AW > 15)
  begin : g_chk
    $error("lac_top parameters out of range");
  end

  lac_state_t state_reg;
  logic [I_W-1:0] sts_reg, mask_reg;
  logic [7:0] cap_reg;
  logic [AW:0] wins_reg, nsmp_reg;
  logic [AW-1:0] pos_reg, radr_reg, e_pos;
  logic [Q_W-1:0] trg_reg, sto_reg;
  logic [3*TW-1:0] mode_reg [NU];
  logic [F_W-1:0] func_reg [NU];
  logic [CNT_W-1:0] n_reg [NU];
  logic [31:0] prdata_reg, rd_mux;
  logic [DW:0] mem [BUF];
  logic e_type, e_force, trg_seen_reg, irq_reg;
  logic [AW:0] e_depth, e_wins, base_reg, off_reg, cnt_reg, post_reg, wcnt_reg;
  logic [NU-1:0] sat, hit, clr_reg;
  logic setup, wr, ctl_wr, arm_wr, stop_wr, cnt_used, cfg_err, trig_cond, store_q;
  logic fire, we, close_win, last_win;
  logic [AW:0] wdepth, new_depth, pre, post_init;

  function automatic logic lac_comb(input logic [NU-1:0] s, input logic [Q_W-1:0] c);
    logic [NU-1:0] t;
    logic [NU-1:0] en;
    t = s ^ c[Q_NEG +: NU];
    en = c[Q_EN +: NU];
    return (c[Q_OR] ? |(t & en) : &(t | ~en)) ^ c[Q_INV];
  endfunction

  function automatic logic lac_mapped(input logic [7:0] a);
    if (a[1:0] != 2'h0)
      return 1'b0;
    if (a <= A_FILL)
      return 1'b1;
    return int'(a) >= int'(A_MU) && int'(a) < int'(A_MU) + NU * MU_STRIDE && a[3:2] != 2'h3;
  endfunction

  // match units
  for (genvar u = 0; u < NU; u++)
  begin : g_mu
    lac_mu_if #(.TW(TW)) mu ();
    assign mu.mode = mode_reg[u];
    assign mu.neg = func_reg[u][F_NEG];
    assign mu.cmode = lac_cnt_t'(func_reg[u][F_CM +: 2]);
    assign mu.n = n_reg[u];
    assign mu.clr = clr_reg[u];
    assign sat[u] = mu.sat;
    assign hit[u] = mu.hit;
    lac_match #(.TW(TW), .EDGE(EDGE)) u_match (
      .mclk_i(mclk_i),
      .rst_b_i(rst_b_i),
      .trig_i(trig_i),
      .mu(mu)
    );
  end

  // apb decode: read data is latched in the setup cycle, so no wait states
  assign setup = psel_i & ~penable_i;
  assign wr = psel_i & penable_i & pwrite_i & lac_mapped(paddr_i);
  assign ctl_wr = wr && paddr_i == A_CTRL;
  assign arm_wr = ctl_wr && (pwdata_i[C_ARM] || pwdata_i[C_FORCE]);
  assign stop_wr = ctl_wr && pwdata_i[C_STOP];
  assign pready_o = 1'b1;
  assign pslverr_o = psel_i & penable_i & ~lac_mapped(paddr_i);
  assign prdata_o = prdata_reg;
  assign irq_o = irq_reg;

  always_comb
  begin
    rd_mux = 32'h00000000;
    if (paddr_i >= A_MU)
    begin
      for (int u = 0; u < NU; u++)
      begin
        if (int'(paddr_i) - int'(A_MU) >= u * MU_STRIDE
            && int'(paddr_i) - int'(A_MU) < (u + 1) * MU_STRIDE)
        begin
          unique case (paddr_i[3:2])
            MU_MODE: rd_mux = 32'(mode_reg[u]);
            MU_FUNC: rd_mux = 32'(func_reg[u]);
            MU_CNT: rd_mux = 32'(n_reg[u]);
            default: rd_mux = 32'h00000000;
          endcase
        end
      end
    end
    else
    begin
      unique case (paddr_i)
        A_CTRL: rd_mux = {29'h00000000, state_reg == ST_DONE, trg_seen_reg,
                          state_reg == ST_PRE || state_reg == ST_POST};
        A_STS: rd_mux = 32'(sts_reg);
        A_MASK: rd_mux = 32'(mask_reg);
        A_CAP: rd_mux = 32'(cap_reg);
        A_WINS: rd_mux = 32'(wins_reg);
        A_POS: rd_mux = 32'(pos_reg);
        A_NSMP: rd_mux = 32'(nsmp_reg);
        A_TRG: rd_mux = 32'(trg_reg);
        A_STO: rd_mux = 32'(sto_reg);
        A_RADR: rd_mux = 32'(radr_reg);
        A_RDAT: rd_mux = 32'(mem[radr_reg]);
        A_FILL: rd_mux = 32'(base_reg);
        default: rd_mux = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      prdata_reg <= 32'h00000000;
    else if (setup && !pwrite_i)
      prdata_reg <= rd_mux;
  end

  // configuration registers
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      mask_reg <= '0;
      cap_reg <= 8'h00;
      wins_reg <= (AW+1)'(1);
      pos_reg <= '0;
      nsmp_reg <= (AW+1)'(1);
      trg_reg <= TRG_RST;
      sto_reg <= STO_RST;
      radr_reg <= '0;
      for (int u = 0; u < NU; u++)
      begin
        mode_reg[u] <= '0;
        func_reg[u] <= '0;
        n_reg[u] <= CNT_RST;
      end
    end
    else if (wr)
    begin
      unique case (paddr_i)
        A_MASK: mask_reg <= pwdata_i[I_W-1:0];
        A_CAP: cap_reg <= pwdata_i[7:0];
        A_WINS: wins_reg <= pwdata_i[AW:0];
        A_POS: pos_reg <= pwdata_i[AW-1:0];
        A_NSMP: nsmp_reg <= pwdata_i[AW:0];
        A_TRG: trg_reg <= pwdata_i[Q_W-1:0];
        A_STO: sto_reg <= pwdata_i[Q_W-1:0];
        A_RADR: radr_reg <= pwdata_i[AW-1:0];
        default:
        begin
          for (int u = 0; u < NU; u++)
          begin
            if (int'(paddr_i) - int'(A_MU) >= u * MU_STRIDE
                && int'(paddr_i) - int'(A_MU) < (u + 1) * MU_STRIDE)
            begin
              if (paddr_i[3:2] == MU_MODE)
                mode_reg[u] <= pwdata_i[3*TW-1:0];
              if (paddr_i[3:2] == MU_FUNC)
                func_reg[u] <= pwdata_i[F_W-1:0];
              if (paddr_i[3:2] == MU_CNT)
                n_reg[u] <= pwdata_i[CNT_W-1:0];
            end
          end
        end
      endcase
    end
  end

  // arm-time checks; a refused arm leaves the state alone and flags an error
  assign wdepth = (AW+1)'(1) << cap_reg[K_LOG +: K_LOG_W];
  assign new_depth = cap_reg[K_TYPE] ? nsmp_reg : wdepth;
  always_comb
  begin
    cnt_used = 1'b0;
    for (int u = 0; u < NU; u++)
    begin
      if (trg_reg[Q_EN + u] && (func_reg[u][F_CM +: 2] == 2'(CM_ATLEAST)
          || func_reg[u][F_CM +: 2] == 2'(CM_CONSEC)))
        cnt_used = 1'b1;
    end
  end
  assign cfg_err = !pwdata_i[C_FORCE] && (
    (cnt_used && new_depth < (AW+1)'(MIN_CNT_DEPTH))
    || (cap_reg[K_TYPE] && (nsmp_reg == '0 || nsmp_reg > (AW+1)'(BUF)))
    || (!cap_reg[K_TYPE] && (cap_reg[K_LOG +: K_LOG_W] > 4'(AW)
        || wins_reg == '0 || wins_reg > (AW+1)'(BUF)
        || {1'b0, pos_reg} >= wdepth)));

  // trigger and storage qualification
  assign trig_cond = lac_comb(sat, trg_reg);
  assign store_q = e_force || sto_reg[Q_ALL] || lac_comb(hit, sto_reg);
  assign fire = state_reg == ST_PRE && (e_force || trig_cond);
  assign we = (state_reg == ST_PRE && (fire || (store_q && e_pos != '0)))
              || (state_reg == ST_POST && store_q);
  assign pre = cnt_reg < {1'b0, e_pos} ? cnt_reg : {1'b0, e_pos};
  assign post_init = e_depth - (AW+1)'(1) - pre;
  assign close_win = (fire && post_init == '0)
                     || (state_reg == ST_POST && we && post_reg == (AW+1)'(1));
  assign last_win = wcnt_reg + (AW+1)'(1) == e_wins
                    || (AW+2)'(base_reg) + (AW+2)'(e_depth) * 2 > (AW+2)'(BUF);

  // clearing counters at the trigger ends at-least and consecutive holds
  always_ff @(posedge mclk_i)
  begin
    clr_reg <= (!rst_b_i || fire || arm_wr || stop_wr) ? '1 : '0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (we)
      mem[AW'(base_reg + off_reg)] <= {fire, data_i};
  end

  // capture sequencer
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      state_reg <= ST_IDLE;
      e_type <= 1'b0;
      e_force <= 1'b0;
      e_depth <= (AW+1)'(1);
      e_pos <= '0;
      e_wins <= (AW+1)'(1);
      base_reg <= '0;
      off_reg <= '0;
      cnt_reg <= '0;
      post_reg <= '0;
      wcnt_reg <= '0;
      trg_seen_reg <= 1'b0;
    end
    else if (stop_wr)
    begin
      state_reg <= ST_IDLE;
      trg_seen_reg <= 1'b0;
    end
    else if (arm_wr && !cfg_err)
    begin
      state_reg <= ST_PRE;
      e_type <= cap_reg[K_TYPE];
      e_force <= pwdata_i[C_FORCE];
      e_depth <= pwdata_i[C_FORCE] ? (AW+1)'(BUF) : new_depth;
      e_pos <= (pwdata_i[C_FORCE] || cap_reg[K_TYPE]) ? '0 : pos_reg;
      e_wins <= pwdata_i[C_FORCE] ? (AW+1)'(1) : (cap_reg[K_TYPE] ? (AW+1)'(BUF) : wins_reg);
      base_reg <= '0;
      off_reg <= '0;
      cnt_reg <= '0;
      wcnt_reg <= '0;
      trg_seen_reg <= 1'b0;
    end
    else if (close_win)
    begin
      state_reg <= last_win ? ST_DONE : ST_PRE;
      base_reg <= base_reg + e_depth;
      off_reg <= '0;
      cnt_reg <= '0;
      wcnt_reg <= wcnt_reg + (AW+1)'(1);
      trg_seen_reg <= 1'b1;
    end
    else if (we)
    begin
      // pre-trigger samples circulate in the window so the oldest drop out
      off_reg <= off_reg == e_depth - (AW+1)'(1) ? '0 : off_reg + (AW+1)'(1);
      if (cnt_reg != e_depth)
        cnt_reg <= cnt_reg + (AW+1)'(1);
      if (fire)
      begin
        state_reg <= ST_POST;
        post_reg <= post_init;
        trg_seen_reg <= 1'b1;
      end
      else if (state_reg == ST_POST)
        post_reg <= post_reg - (AW+1)'(1);
    end
  end

  // sticky events, write one to clear; a new event wins over its clear
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      sts_reg <= '0;
      irq_reg <= 1'b0;
    end
    else
    begin
      sts_reg <= (sts_reg & ~((wr && paddr_i == A_STS) ? pwdata_i[I_W-1:0] : '0))
                 | {arm_wr && cfg_err, close_win && last_win, fire};
      irq_reg <= |(sts_reg & mask_reg);
    end
  end

  default clocking @(posedge mclk_i); endclocking
  default disable iff (!rst_b_i);
  one_trigger_a: assert property ((state_reg == ST_POST && we) |-> !fire)
    else $error("second trigger inside a window");
  cap_hold_a: assert property (!(wr && paddr_i == A_CAP) |=> $stable(cap_reg))
    else $error("capture setting changed without a write");
  trig_pos_a: assert property (
    (fire && cnt_reg >= {1'b0, e_pos} && post_init != '0 && !stop_wr && !arm_wr)
      |=> (state_reg == ST_POST && post_reg == e_depth - (AW+1)'(1) - e_pos))
    else $error("trigger not at programmed position");
  nsamp_first_a: assert property ((fire && e_type) |-> off_reg == '0)
    else $error("fixed-samples trigger not first in window");
  short_depth_a: assert property (
    (arm_wr && !pwdata_i[C_FORCE] && cnt_used && new_depth < (AW+1)'(MIN_CNT_DEPTH)
      && !stop_wr && !fire && !close_win)
      |=> (state_reg == $past(state_reg) && sts_reg[I_ERR]))
    else $error("arm accepted with too short window");
  store_gate_a: assert property ((state_reg == ST_PRE && !fire && !store_q) |-> !we)
    else $error("unqualified sample stored");
  trig_fire_a: assert property ((state_reg == ST_PRE && trig_cond) |-> fire)
    else $error("trigger condition ignored while armed");
  done_stop_a: assert property ((state_reg == ST_DONE && !ctl_wr) |=>
    (state_reg == ST_DONE && !we)) else $error("capture continued after buffer full");
  irq_level_a: assert property (|(sts_reg & mask_reg) |=> irq_o)
    else $error("interrupt missing for unmasked status");
endmodule
`default_nettype wire

// >>> sim/lac_probe_model.sv
`timescale 1ns/1ns
`default_nettype none
module lac_probe_model #(
  parameter int TW = 8,
  parameter int DW = 8
) (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // pattern asked for by the bench
  input wire logic [TW-1:0] trig_req_i,
  // probed ports
  output logic [TW-1:0] trig_o,
  output logic [DW-1:0] data_o
);
  logic [DW-1:0] cnt_reg;
  // a running count, so any gap or reordering inside a stored window shows up
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      cnt_reg <= '0;
    else
      cnt_reg <= cnt_reg + 1'h1;
  end
  assign data_o = cnt_reg;
  // no delay on trigger bits, so the bench knows which data word meets an event
  assign trig_o = trig_req_i;
endmodule
`default_nettype wire

// >>> sim/lac_top_bench.sv
`timescale 1ns/1ns
`default_nettype none
module lac_top_bench;
  import lac_pkg::*;
  localparam int TW = 8;
  localparam int DW = 8;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [TW-1:0] trig;
  logic [DW-1:0] data;
  logic irq;
  logic fire = 1'h0;
  logic [31:0] rnd = 32'hF7CEE5BB;
  logic [TW-1:0] trig_req;
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  // low trigger bit carries planted events, the others are noise
  assign trig_req = {rnd[TW-1:1], fire};
  always #50 mclk = ~mclk;
  lac_probe_model #(.TW(TW), .DW(DW)) u_lac_probe_model (
    .mclk_i(mclk),
    .rst_b_i(rst_b),
    .trig_req_i(trig_req),
    .trig_o(trig),
    .data_o(data)
  );
  lac_top #(.TW(TW), .DW(DW), .AW(6), .NU(2), .EDGE(1'h1)) u_lac_top (
    .mclk_i(mclk),
    .rst_b_i(rst_b),
    .psel_i(psel),
    .penable_i(penable),
    .pwrite_i(pwrite),
    .paddr_i(paddr),
    .pwdata_i(pwdata),
    .prdata_o(prdata),
    .pready_o(pready),
    .pslverr_o(pslverr),
    .trig_i(trig),
    .data_i(data),
    .irq_o(irq)
  );
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  always @(posedge mclk)
    rnd <= xs(rnd);
  task automatic end_of_test();
    $display("mismatches %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_total++;
      end_of_test();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    do
    begin
      @(posedge mclk);
    end
    while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'h1, a, d, r, e);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    logic e;
    apb(1'h0, a, 32'h0, r, e);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    rd(a, r);
    chk(r, exp, "register read");
  endtask
  task automatic capture(input logic [31:0] cap, input logic [7:0] ka, input int kv,
                         input int nwin, input int len, input int pos);
    logic [31:0] r;
    logic [DW-1:0] tv [4];
    logic [DW:0] buff [64];
    logic [DW-1:0] ev;
    int n;
    int m;
    int marks;
    wr(A_CAP, cap);
    wr(ka, 32'(kv));
    wr(A_POS, 32'(pos));
    wr(A_MASK, 32'h2);
    wr(A_STS, 32'h7);
    wr(A_CTRL, 32'h1);
    rchk(A_CTRL, 32'h1);
    for (int w = 0; w < nwin; w++)
    begin
      rd(A_CTRL, r);
      chk(32'(r[2]), 32'h0, "done too early");
      repeat (10 + int'(rnd[2:0])) @(posedge mclk);
      fire <= 1'h1;
      #1 tv[w] = data;
      @(posedge mclk);
      fire <= 1'h0;
      // a second event inside the post-trigger run must not open a window
      if (len - pos > 3)
      begin
        @(posedge mclk);
        fire <= 1'h1;
        @(posedge mclk);
        fire <= 1'h0;
      end
      repeat (len - pos + 2) @(posedge mclk);
    end
    n = 0;
    do
    begin
      rd(A_CTRL, r);
      n++;
    end
    while (r[2] !== 1'h1 && n < 40);
    chk(r & 32'h4, 32'h4, "done flag");
    rchk(A_STS, 32'h3);
    chk(32'(irq), 32'h1, "irq set");
    wr(A_STS, 32'h2);
    repeat (2) @(posedge mclk);
    chk(32'(irq), 32'h0, "irq clear");
    rchk(A_FILL, 32'(nwin * len));
    for (int w = 0; w < nwin; w++)
    begin
      marks = 0;
      m = 0;
      for (int i = 0; i < len; i++)
      begin
        wr(A_RADR, 32'(w * len + i));
        rd(A_RDAT, r);
        buff[i] = r[DW:0];
        if (r[DW] === 1'h1)
        begin
          marks++;
          m = i;
        end
      end
      chk(32'(marks), 32'h1, "marks per window");
      if (pos == 0)
        chk(32'(m), 32'h0, "mark index");
      for (int k = -pos; k < len - pos; k++)
      begin
        ev = tv[w] + k[DW-1:0];
        chk(32'(buff[(m + k + len) % len][DW-1:0]), 32'(ev), "window data");
      end
    end
  endtask
  initial
  begin
    logic [31:0] r;
    logic e;
    repeat (10) @(posedge mclk);
    rst_b <= 1'h1;
    rchk(A_TRG, 32'h000000FF);
    rchk(A_STO, 32'h00040000);
    rchk(A_WINS, 32'h1);
    rchk(A_NSMP, 32'h1);
    rchk(A_MU + 8'h08, 32'h1);
    apb(1'h0, 8'h3C, 32'h0, r, e);
    chk(32'(e), 32'h1, "unmapped error");
    chk(r, 32'h0, "unmapped data");
    for (int c = 0; c < 7; c++)
    begin
      wr(A_MU + 8'h10, 32'(c));
      rchk(A_MU + 8'h10, 32'(c));
    end
    for (int c = 0; c < 4; c++)
    begin
      wr(A_MU + 8'h14, 32'(c << F_CM));
      rchk(A_MU + 8'h14, 32'(c << F_CM));
    end
    wr(A_MU + 8'h10, 32'h0);
    wr(A_MU + 8'h14, 32'h0);
    wr(A_MU, 32'(BM_ONE));
    wr(A_TRG, 32'h1);
    capture(32'h30, A_WINS, 2, 2, 8, 7);
    capture(32'h30, A_WINS, 2, 2, 8, 3);
    capture(32'h1, A_NSMP, 20, 3, 20, 0);
    capture(32'h1, A_NSMP, 64, 1, 64, 0);
    wr(A_MU, 32'(BM_RISE));
    wr(A_STO, 32'h00020001);
    capture(32'h20, A_WINS, 2, 2, 4, 1);
    wr(A_POS, 32'h8);
    wr(A_CAP, 32'h30);
    wr(A_STS, 32'h7);
    wr(A_CTRL, 32'h1);
    rchk(A_STS, 32'h4);
    rd(A_CTRL, r);
    chk(r & 32'h1, 32'h0, "refused arm");
    wr(A_POS, 32'h0);
    wr(A_CTRL, 32'h1);
    wr(A_CTRL, 32'h2);
    rchk(A_CTRL, 32'h0);
    wr(A_CTRL, 32'h4);
    repeat (80) @(posedge mclk);
    rchk(A_CTRL, 32'h6);
    rchk(A_FILL, 32'h40);
    wr(A_RADR, 32'h0);
    rd(A_RDAT, r);
    chk(32'(r[DW]), 32'h1, "forced mark");
    wr(A_MU + 8'h04, 32'h20);
    wr(A_CAP, 32'h20);
    wr(A_STS, 32'h7);
    wr(A_CTRL, 32'h1);
    rchk(A_STS, 32'h4);
    end_of_test();
  end
endmodule
`default_nettype wire
